// >>> hdl/module_indicator_a_alarm_pkg.sv
// constants and types shared by the diagnostic alarm encoder
package module_indicator_a_alarm_pkg;

  // ---------------------------------------------------------------
  // structure
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int KINDS_PER_CH = 12;
  localparam int MOD_EVENTS = 4;
  localparam int NUM_EVENTS = MOD_EVENTS + NUM_CH * KINDS_PER_CH;
  localparam int IDX_W = 6;
  localparam int CODE_W = 16;

  // module-level event slots
  localparam int M_UNAVAIL = 0;
  localparam int M_OVERTEMP = 1;
  localparam int M_PARAM = 2;
  localparam int M_SUPPLY = 3;

  // per-channel event slots
  localparam int K_SHORT = 0;
  localparam int K_WIRE = 1;
  localparam int K_HIGH = 2;
  localparam int K_LOW = 3;
  localparam int K_COMM = 4;
  localparam int K_PV = 5;
  localparam int K_SAT = 6;
  localparam int K_FIXED = 7;
  localparam int K_NONPV = 8;
  localparam int K_MORE = 9;
  localparam int K_CFG = 10;
  localparam int K_MALF = 11;
  localparam int K_FIRST_HART = K_COMM;

  // ---------------------------------------------------------------
  // error codes
  // ---------------------------------------------------------------
  localparam logic [CODE_W-1:0] MOD_CODES [MOD_EVENTS] = '{
    16'h001F, 16'h0005, 16'h0010, 16'h0011};
  localparam logic [CODE_W-1:0] CH_CODES [KINDS_PER_CH] = '{
    16'h0001, 16'h0006, 16'h0007, 16'h0008, 16'h0141, 16'h0142,
    16'h0143, 16'h0144, 16'h0149, 16'h0145, 16'h0146, 16'h0147};
  localparam logic [CODE_W-1:0] CODE_UNAVAIL = 16'h001F;

  // ---------------------------------------------------------------
  // field device status bytes
  // ---------------------------------------------------------------
  localparam int ST1_COMM_ERR_BIT = 7;
  localparam logic [7:0] ST1_CMD_REJECT = 8'h40;
  localparam int ST2_MALF_BIT = 7;
  localparam int ST2_CFG_BIT = 6;
  localparam int ST2_MORE_BIT = 4;
  localparam int ST2_FIXED_BIT = 3;
  localparam int ST2_SAT_BIT = 2;
  localparam int ST2_NONPV_BIT = 1;
  localparam int ST2_PV_BIT = 0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 50_000_000;
  localparam longint CFG_CLEAR_S = 60;
  localparam logic [31:0] CFG_CLEAR_CYCLES = 32'(CFG_CLEAR_S * CLK_HZ);
  localparam longint BLINK_HALF_MS = 250;
  localparam logic [31:0] BLINK_HALF_CYCLES = 32'(BLINK_HALF_MS * CLK_HZ / 1000);

  typedef enum logic {ALM_IDLE, ALM_WAIT} alarm_state_type;

endpackage

// >>> hdl/output_module_module_indicator_a_alarm_encoder.sv
// diagnostic event collector, alarm encoder and indicator driver
//
// Operation
// - diagnostic interrupt for every listed module and channel condition
// - one alarm per detected event; module indicator flashes while any present
// - channel fault and status indicators show each channel's diagnostics
// - firmware update running or cancelled reports 1F and suspends processing
// - shorted actuator cable or low load impedance reports code 1
// - overtemperature reports code 5
// - open channel or broken line reports code 6
// - analog value above overrange reports code 7
// - analog value below underrange reports code 8
// - invalid configuration reports code 10
// - missing or insufficient load supply reports code 11
// - no reply, timing error or rejected command reports code 141
// - primary variable outside limits reports code 142
// - field device output current saturated reports code 143
// - field device output current fixed reports code 144
// - non-primary variable outside limits reports code 149
// - more-status flag in second status byte reports code 145
// - configuration-changed flag reports code 146, cleared after about a minute
// - malfunction flag in second status byte reports code 147
// - channel diagnostics: status off, fault on; HART only: both on
`timescale 1ns/1ns
`default_nettype none

module output_module_module_indicator_a_alarm_encoder #(
  parameter logic [31:0] CFG_CLEAR_CYCLES = module_indicator_a_alarm_pkg::CFG_CLEAR_CYCLES,
  parameter logic [31:0] BLINK_HALF_CYCLES = module_indicator_a_alarm_pkg::BLINK_HALF_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // module conditions
  input wire logic fw_update_active,
  input wire logic fw_update_cancelled,
  input wire logic params_assigned,
  input wire logic param_invalid,
  input wire logic overtemp_detect,
  input wire logic supply_missing,
  // channel conditions
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] channel_enable,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] short_detect,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] wire_break_detect,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] high_limit_detect,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] low_limit_detect,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] cfg_irq_enable,
  // field device replies
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] hart_reply_valid,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] hart_no_reply,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] hart_timing_error,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0][7:0] hart_status1,
  input wire logic [module_indicator_a_alarm_pkg::NUM_CH-1:0][7:0] hart_status2,
  // alarm to host
  input wire logic alarm_ack,
  output logic alarm_valid,
  output logic [module_indicator_a_alarm_pkg::CODE_W-1:0] alarm_code,
  output logic [1:0] alarm_channel,
  output logic alarm_module_level,
  // indicators
  output logic module_indicator_a,
  output logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] channel_status_led,
  output logic [module_indicator_a_alarm_pkg::NUM_CH-1:0] channel_fault_led
);
  import module_indicator_a_alarm_pkg::*;

  function automatic int ev_idx(input int ch, input int kind);
    ev_idx = MOD_EVENTS + ch * KINDS_PER_CH + kind;
  endfunction

  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_EVENTS-1:0] v);
    first_set = '0;
    for (int i = NUM_EVENTS - 1; i >= 0; i--)
    begin
      if (v[i])
        first_set = IDX_W'(i);
    end
  endfunction

  function automatic logic [CODE_W-1:0] code_of(input logic [IDX_W-1:0] idx);
    if (int'(idx) < MOD_EVENTS)
      code_of = MOD_CODES[int'(idx)];
    else
      code_of = CH_CODES[(int'(idx) - MOD_EVENTS) % KINDS_PER_CH];
  endfunction

  logic busy;
  logic [NUM_EVENTS-1:0] cond;
  logic [NUM_EVENTS-1:0] allow;
  logic [NUM_EVENTS-1:0] set_vec;
  logic [NUM_EVENTS-1:0] clr_vec;
  logic [NUM_EVENTS-1:0] cond_reg;
  logic [NUM_EVENTS-1:0] pend_reg;
  logic [NUM_EVENTS-1:0] pend_next;
  logic [NUM_CH-1:0] hart_comm_reg;
  logic [NUM_CH-1:0][7:0] hart_dev_reg;
  logic [NUM_CH-1:0] cfg_flag_reg;
  logic [NUM_CH-1:0][31:0] cfg_timer_reg;
  logic [IDX_W-1:0] sel_idx;
  alarm_state_type state_reg;
  logic alarm_valid_reg;
  logic [CODE_W-1:0] alarm_code_reg;
  logic [1:0] alarm_channel_reg;
  logic alarm_module_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic module_ind_reg;
  logic [NUM_CH-1:0] status_led_reg;
  logic [NUM_CH-1:0] fault_led_reg;

  // ---------------------------------------------------------------
  // condition collection
  // ---------------------------------------------------------------
  assign busy = fw_update_active | fw_update_cancelled;

  always_comb
  begin
    cond = '0;
    cond[M_UNAVAIL] = busy;
    // everything else reads as clear while the firmware is away
    if (!busy)
    begin
      cond[M_OVERTEMP] = overtemp_detect;
      cond[M_PARAM] = param_invalid;
      cond[M_SUPPLY] = supply_missing;
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        if (channel_enable[ch])
        begin
          cond[ev_idx(ch, K_SHORT)] = short_detect[ch];
          cond[ev_idx(ch, K_WIRE)] = wire_break_detect[ch];
          cond[ev_idx(ch, K_HIGH)] = high_limit_detect[ch];
          cond[ev_idx(ch, K_LOW)] = low_limit_detect[ch];
          cond[ev_idx(ch, K_COMM)] = hart_comm_reg[ch];
          cond[ev_idx(ch, K_PV)] = hart_dev_reg[ch][ST2_PV_BIT];
          cond[ev_idx(ch, K_SAT)] = hart_dev_reg[ch][ST2_SAT_BIT];
          cond[ev_idx(ch, K_FIXED)] = hart_dev_reg[ch][ST2_FIXED_BIT];
          cond[ev_idx(ch, K_NONPV)] = hart_dev_reg[ch][ST2_NONPV_BIT];
          cond[ev_idx(ch, K_MORE)] = hart_dev_reg[ch][ST2_MORE_BIT];
          cond[ev_idx(ch, K_CFG)] = cfg_flag_reg[ch];
          cond[ev_idx(ch, K_MALF)] = hart_dev_reg[ch][ST2_MALF_BIT];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // field device status capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hart_comm_reg <= '0;
      hart_dev_reg <= '0;
    end
    else if (!busy)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        if (hart_no_reply[ch] || hart_timing_error[ch])
        begin
          hart_comm_reg[ch] <= 1'b1;
          hart_dev_reg[ch] <= '0;
        end
        else if (hart_reply_valid[ch])
        begin
          // a rejected command carries no valid device status
          if (hart_status1[ch][ST1_COMM_ERR_BIT] || hart_status1[ch] == ST1_CMD_REJECT)
          begin
            hart_comm_reg[ch] <= 1'b1;
            hart_dev_reg[ch] <= '0;
          end
          else
          begin
            hart_comm_reg[ch] <= 1'b0;
            hart_dev_reg[ch] <= hart_status2[ch];
          end
        end
      end
    end
  end

  // configuration-changed flag clears itself; a new report restarts the wait
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_flag_reg <= '0;
      cfg_timer_reg <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        if (!busy && hart_reply_valid[ch] && !hart_no_reply[ch] && !hart_timing_error[ch]
            && !hart_status1[ch][ST1_COMM_ERR_BIT] && hart_status1[ch] != ST1_CMD_REJECT
            && hart_status2[ch][ST2_CFG_BIT])
        begin
          cfg_flag_reg[ch] <= 1'b1;
          cfg_timer_reg[ch] <= '0;
        end
        else if (cfg_flag_reg[ch])
        begin
          if (cfg_timer_reg[ch] >= CFG_CLEAR_CYCLES - 32'h0000_0001)
            cfg_flag_reg[ch] <= 1'b0;
          else
            cfg_timer_reg[ch] <= cfg_timer_reg[ch] + 32'h0000_0001;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // event detection and pending alarms
  // ---------------------------------------------------------------
  always_comb
  begin
    allow = '1;
    for (int ch = 0; ch < NUM_CH; ch++)
      allow[ev_idx(ch, K_CFG)] = cfg_irq_enable[ch];
  end

  assign set_vec = cond & ~cond_reg & allow;
  assign sel_idx = first_set(pend_reg);

  always_comb
  begin
    clr_vec = '0;
    if (state_reg == ALM_IDLE && |pend_reg)
      clr_vec[sel_idx] = 1'b1;
    // pending alarms that were queued before the update are dropped
    if (busy)
      clr_vec = clr_vec | ~(NUM_EVENTS'(1) << M_UNAVAIL);
  end

  // a new event in the clearing cycle survives
  assign pend_next = (pend_reg & ~clr_vec) | set_vec;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cond_reg <= '0;
      pend_reg <= '0;
    end
    else
    begin
      cond_reg <= cond;
      pend_reg <= pend_next;
    end
  end

  // ---------------------------------------------------------------
  // alarm presentation, held until the host acknowledges
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ALM_IDLE;
      alarm_valid_reg <= 1'b0;
      alarm_code_reg <= '0;
      alarm_channel_reg <= '0;
      alarm_module_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ALM_IDLE:
        begin
          if (|pend_reg)
          begin
            state_reg <= ALM_WAIT;
            alarm_valid_reg <= 1'b1;
            alarm_code_reg <= code_of(sel_idx);
            alarm_module_reg <= int'(sel_idx) < MOD_EVENTS;
            if (int'(sel_idx) < MOD_EVENTS)
              alarm_channel_reg <= '0;
            else
              alarm_channel_reg <= 2'((int'(sel_idx) - MOD_EVENTS) / KINDS_PER_CH);
          end
        end
        ALM_WAIT:
        begin
          if (alarm_ack)
          begin
            state_reg <= ALM_IDLE;
            alarm_valid_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b0;
    end
    else if (blink_cnt_reg >= BLINK_HALF_CYCLES - 32'h0000_0001)
    begin
      blink_cnt_reg <= '0;
      blink_reg <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      module_ind_reg <= 1'b0;
      status_led_reg <= '0;
      fault_led_reg <= '0;
    end
    else
    begin
      // unassigned parameters and active diagnostics both flash
      if (!params_assigned || |cond)
        module_ind_reg <= blink_reg;
      else
        module_ind_reg <= 1'b1;
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        status_led_reg[ch] <= channel_enable[ch]
          && !(|cond[ev_idx(ch, 0) +: K_FIRST_HART]);
        fault_led_reg[ch] <= |cond[ev_idx(ch, 0) +: KINDS_PER_CH];
      end
    end
  end

  assign alarm_valid = alarm_valid_reg;
  assign alarm_code = alarm_code_reg;
  assign alarm_channel = alarm_channel_reg;
  assign alarm_module_level = alarm_module_reg;
  assign module_indicator_a = module_ind_reg;
  assign channel_status_led = status_led_reg;
  assign channel_fault_led = fault_led_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_launch;
    state_reg == ALM_IDLE && |pend_reg;
  endsequence

  chk_alarm_hold: assert property (alarm_valid && !alarm_ack
    |=> alarm_valid && $stable(alarm_code) && $stable(alarm_channel))
    else $error("alarm changed before acknowledge");
  chk_event_queued: assert property (|set_vec |=> |pend_reg || alarm_valid)
    else $error("detected event was not queued");
  chk_unavail_first: assert property (s_launch ##0 pend_reg[M_UNAVAIL]
    |=> alarm_valid && alarm_code == CODE_UNAVAIL && alarm_module_level)
    else $error("unavailable alarm did not take priority");
  chk_busy_silences: assert property (busy [*2] |-> pend_reg[NUM_EVENTS-1:1] == '0)
    else $error("alarms kept pending during firmware update");
  chk_short_led: assert property (cond[ev_idx(0, K_SHORT)]
    |=> channel_fault_led[0] && !channel_status_led[0])
    else $error("channel indicators wrong for channel fault");
  chk_hart_only_led: assert property (cond[ev_idx(2, K_COMM)]
    && cond[ev_idx(2, 0) +: K_FIRST_HART] == '0
    |=> channel_fault_led[2] && channel_status_led[2])
    else $error("channel indicators wrong for field device diagnostics");
  chk_comm_latch: assert property (!busy && |(hart_no_reply | hart_timing_error)
    |=> (hart_comm_reg & $past(hart_no_reply | hart_timing_error))
    == $past(hart_no_reply | hart_timing_error))
    else $error("missing reply not recorded");
  chk_cfg_expire: assert property (cfg_flag_reg[1] && !hart_reply_valid[1]
    && cfg_timer_reg[1] >= CFG_CLEAR_CYCLES - 32'h0000_0001 |=> !cfg_flag_reg[1])
    else $error("configuration change not cleared on time");
  chk_cfg_gated: assert property (!cfg_irq_enable[1] && !pend_reg[ev_idx(1, K_CFG)]
    |=> !pend_reg[ev_idx(1, K_CFG)])
    else $error("disabled configuration change alarm queued");
  chk_indicator_flash: assert property (|cond && params_assigned
    |=> module_indicator_a == $past(blink_reg))
    else $error("module indicator not flashing with diagnostics");

endmodule

`default_nettype wire

// >>> sim/host_alarm_sink.sv
// host model that accepts and records diagnostic alarms
`timescale 1ns/1ns
`default_nettype none
module host_alarm_sink (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // alarm from the device
  input wire logic alarm_valid,
  input wire logic [module_indicator_a_alarm_pkg::CODE_W-1:0] alarm_code,
  input wire logic [1:0] alarm_channel,
  input wire logic alarm_module_level,
  // acceptance
  input wire logic [3:0] ack_delay,
  output logic alarm_ack
);
  import module_indicator_a_alarm_pkg::*;
  logic [CODE_W+2:0] got[$];
  int wait_cnt = 0;
  initial alarm_ack = 1'h0;
  // ack is a one-cycle pulse; a slow host lets the alarm stand for ack_delay + 1 cycles
  always @(posedge core_clk)
  begin
    #1;
    if (!reset_n || alarm_ack)
    begin
      alarm_ack = 1'h0;
      wait_cnt = 0;
    end
    else if (alarm_valid && wait_cnt >= ack_delay)
    begin
      got.push_back({alarm_module_level, alarm_channel, alarm_code});
      alarm_ack = 1'h1;
    end
    else if (alarm_valid)
      wait_cnt++;
  end
endmodule
`default_nettype wire

// >>> sim/output_module_module_indicator_a_alarm_encoder_bench.sv
// self-checking bench for the diagnostic alarm encoder
`timescale 1ns/1ns
`default_nettype none
module output_module_module_indicator_a_alarm_encoder_bench;
  import module_indicator_a_alarm_pkg::*;
  localparam int CLR = 20;
  localparam int HALF = 4;
  logic core_clk = '0, reset_n = '0, fw_update_active = '0, fw_update_cancelled = '0;
  logic params_assigned = '1, param_invalid = '0, overtemp_detect = '0, supply_missing = '0;
  logic [3:0] channel_enable = '1, short_detect = '0, wire_break_detect = '0;
  logic [3:0] high_limit_detect = '0, low_limit_detect = '0, cfg_irq_enable = '0;
  logic [3:0] hart_reply_valid = '0, hart_no_reply = '0, hart_timing_error = '0;
  logic [3:0][7:0] hart_status1 = '0, hart_status2 = '0;
  logic [3:0] ack_delay = '0, channel_status_led, channel_fault_led;
  logic alarm_ack, alarm_valid, alarm_module_level, module_indicator_a;
  logic [CODE_W-1:0] alarm_code;
  logic [1:0] alarm_channel;
  int miscompares = 0, checks = 0;

  always #10 core_clk = ~core_clk;

  output_module_module_indicator_a_alarm_encoder #(.CFG_CLEAR_CYCLES(32'(CLR)),
    .BLINK_HALF_CYCLES(32'(HALF))) i_dut (.core_clk, .reset_n, .fw_update_active,
    .fw_update_cancelled, .params_assigned, .param_invalid, .overtemp_detect,
    .supply_missing, .channel_enable, .short_detect, .wire_break_detect,
    .high_limit_detect, .low_limit_detect, .cfg_irq_enable, .hart_reply_valid,
    .hart_no_reply, .hart_timing_error, .hart_status1, .hart_status2, .alarm_ack,
    .alarm_valid, .alarm_code, .alarm_channel, .alarm_module_level,
    .module_indicator_a, .channel_status_led, .channel_fault_led);

  host_alarm_sink i_host (.core_clk, .reset_n, .alarm_valid, .alarm_code,
    .alarm_channel, .alarm_module_level, .ack_delay, .alarm_ack);

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic expect_alarm(input logic [15:0] c, input logic [1:0] ch, input logic m);
    int n;
    n = 0;
    while (i_host.got.size() == 0)
    begin
      if (n++ > 60)
      begin
        check("alarm arrival", 1, 0);
        give_verdict();
      end
      tick(1);
    end
    check("alarm", {m, ch, c}, i_host.got.pop_front());
  endtask

  task automatic expect_none(input int n);
    tick(n);
    check("alarm count", 0, i_host.got.size());
  endtask

  task automatic check_blink(input logic blink);
    logic seen0, seen1;
    seen0 = '0;
    seen1 = '0;
    repeat (2 * HALF + 2)
    begin
      tick(1);
      seen0 |= !module_indicator_a;
      seen1 |= module_indicator_a;
    end
    check("module lamp", {blink, 1'h1}, {seen0, seen1});
  endtask

  task automatic hart(input int kind, input int ch, input logic [7:0] s1,
                      input logic [7:0] s2);
    hart_status1[ch] = s1;
    hart_status2[ch] = s2;
    case (kind)
      0: hart_reply_valid[ch] = '1;
      1: hart_no_reply[ch] = '1;
      default: hart_timing_error[ch] = '1;
    endcase
    tick(1);
    hart_reply_valid = '0;
    hart_no_reply = '0;
    hart_timing_error = '0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_module();
    logic [15:0] mc[3] = '{16'h0005, 16'h0010, 16'h0011};
    for (int i = 0; i < 3; i++)
    begin
      overtemp_detect = (i == 0);
      param_invalid = (i == 1);
      supply_missing = (i == 2);
      expect_alarm(mc[i], 2'h0, 1'h1);
      check_blink(1'h1);
      check("fault lamps", 0, channel_fault_led);
      {overtemp_detect, param_invalid, supply_missing} = '0;
      expect_none(5);
      check_blink(1'h0);
    end
    params_assigned = '0;
    check_blink(1'h1);
    params_assigned = '1;
  endtask

  task automatic t_channel();
    logic [15:0] kc[4] = '{16'h0001, 16'h0006, 16'h0007, 16'h0008};
    for (int ch = 0; ch < 4; ch++)
      for (int k = 0; k < 4; k++)
      begin
        {short_detect[ch], wire_break_detect[ch]} = {k == 0, k == 1};
        {high_limit_detect[ch], low_limit_detect[ch]} = {k == 2, k == 3};
        expect_alarm(kc[k], 2'(ch), 1'h0);
        check("lamps on fault", 2'h1, {channel_status_led[ch], channel_fault_led[ch]});
        {short_detect, wire_break_detect, high_limit_detect, low_limit_detect} = '0;
        tick(2);
        check("lamps healthy", 2'h2, {channel_status_led[ch], channel_fault_led[ch]});
      end
    channel_enable[1] = '0;
    short_detect[1] = '1;
    expect_none(10);
    check("disabled status", 0, channel_status_led[1]);
    short_detect[1] = '0;
    channel_enable[1] = '1;
  endtask

  task automatic t_hart();
    int bits[6] = '{ST2_PV_BIT, ST2_NONPV_BIT, ST2_SAT_BIT, ST2_FIXED_BIT, ST2_MORE_BIT,
                    ST2_MALF_BIT};
    logic [15:0] hc[6] = '{16'h0142, 16'h0149, 16'h0143, 16'h0144, 16'h0145, 16'h0147};
    for (int i = 0; i < 10; i++)
    begin
      if (i < 6)
        hart(0, 2, 8'h00, 8'(1 << bits[i]));
      else
        hart(i - 7 < 0 ? 0 : i - 7, 2, i == 6 ? 8'h80 : ST1_CMD_REJECT, 8'h00);
      expect_alarm(i < 6 ? hc[i] : 16'h0141,
        2'h2, 1'h0);
      check("hart lamps", 2'h3, {channel_status_led[2], channel_fault_led[2]});
      hart(0, 2, 8'h00, 8'h00);
      expect_none(4);
      check("hart cleared", 0, channel_fault_led[2]);
    end
  endtask

  task automatic t_cfg();
    cfg_irq_enable[1] = '0;
    hart(0, 1, 8'h00, 8'(1 << ST2_CFG_BIT));
    expect_none(6);
    check("cfg lamp", 1, channel_fault_led[1]);
    cfg_irq_enable[1] = '1;
    tick(CLR);
    check("cfg cleared", 0, channel_fault_led[1]);
    hart(0, 1, 8'h00, 8'(1 << ST2_CFG_BIT));
    expect_alarm(16'h0146, 2'h1, 1'h0);
    tick(CLR - 10);
    check("cfg held", 1, channel_fault_led[1]);
    tick(12);
    check("cfg cleared", 0, channel_fault_led[1]);
    expect_none(2);
  endtask

  task automatic t_firmware();
    ack_delay = 4'h5;
    wire_break_detect[1] = '1;
    low_limit_detect[1] = '1;
    tick(2);
    // the presented alarm survives the update; the one queued behind it is dropped
    short_detect[0] = '1;
    fw_update_active = '1;
    expect_alarm(16'h0006, 2'h1, 1'h0);
    expect_alarm(16'h001F, 2'h0, 1'h1);
    {wire_break_detect, low_limit_detect} = '0;
    ack_delay = 4'h0;
    expect_none(10);
    fw_update_active = '0;
    expect_alarm(16'h0001, 2'h0, 1'h0);
    fw_update_cancelled = '1;
    expect_alarm(16'h001F, 2'h0, 1'h1);
    short_detect[0] = '0;
    fw_update_cancelled = '0;
    expect_none(8);
  endtask

  task automatic t_queue();
    ack_delay = 4'h5;
    supply_missing = '1;
    wire_break_detect[3] = '1;
    low_limit_detect[0] = '1;
    expect_alarm(16'h0011, 2'h0, 1'h1);
    expect_alarm(16'h0008, 2'h0, 1'h0);
    expect_alarm(16'h0006, 2'h3, 1'h0);
    {supply_missing, wire_break_detect, low_limit_detect} = '0;
    ack_delay = 4'h0;
    expect_none(8);
  endtask

  initial
  begin
    tick(2);
    check("reset outputs", 0, {alarm_valid, alarm_code, alarm_channel, alarm_module_level,
      module_indicator_a, channel_status_led, channel_fault_led});
    tick(3);
    reset_n = '1;
    check_blink(1'h0);
    t_module();
    t_channel();
    t_hart();
    t_cfg();
    t_firmware();
    t_queue();
    give_verdict();
  end
endmodule
`default_nettype wire
